// ===== src/rq_host_defines.vh
// Constants for the requester request host controller.
// Behaviour
// RULE1 - Device uses low 128 or 64 data bits in narrow modes; host drives 256.
// RULE2 - Sideband counts only while valid is high; host drives zero otherwise.
// RULE3 - Host raises last in the final beat, or the first beat if single.
// RULE4 - Keep bits contiguous; all ones except a partial final beat.
// RULE5 - Device ignores keep 7:4 or 7:2 in narrow modes; host drives all eight.
// RULE6 - Host keeps valid high from first beat to last beat of a packet.
// RULE7 - A beat moves only when valid and ready are high; host holds otherwise.
// RULE8 - Device ready is four bits; host treats them as one indication.
// RULE9 - Device returns the request sequence number on the progress output.
// RULE10 - Progress valid is a one-cycle pulse per reported number.
// RULE11 - Device-managed tags arrive as a 10-bit tag with a one-cycle valid.
// RULE12 - Tags arrive later in request order; host records every one; the code drops one arriving while all 4 entries are full and none is read in that cycle.
// RULE13 - First dword byte enables sit in sideband 3:0, taken in first beat.
// RULE14 - Last dword byte enables sit in 7:4; zero for one-dword transfers.
// RULE15 - Address-aligned mode puts start byte lane modulo 4 in bits 10:8.
// RULE16 - Address offset is zero in dword-aligned mode and for config packets.
// RULE17 - Abort flag at sideband bit 11 makes the device nullify the packet.
// RULE18 - Host may end an aborted packet early; device keeps abort sticky.
// RULE19 - No abort on non-posted or first beat; hold abort until ready.
// RULE20 - As endpoint the device reports user aborts through error reporting.
// RULE21 - Sequence number low bits sit in sideband 27:24, taken in first beat.
// RULE22 - With parity enabled, bits 59:28 carry odd parity per data byte.
// RULE23 - Sideband 61:60 carry the two upper sequence number bits.
// RULE24 - Unused sideband bits such as 23:12 are driven to zero.
`ifndef RQ_HOST_DEFINES_VH
`define RQ_HOST_DEFINES_VH

`define DATA_W          256
`define KEEP_W          8
`define SIDEBAND_W      62
`define BEATS           4

`define OFF_CTRL        8'h00
`define OFF_DESC        8'h04
`define OFF_STATUS      8'h08
`define OFF_TAG         8'h0c
`define BUF_SEL_BIT     7

`define CTRL_GO         0
`define CTRL_ABORT_EN   1
`define CTRL_PARITY_EN  2
`define CTRL_ADDR_ALIGN 3
`define CTRL_POSTED     4
`define CTRL_ABT_LO     8
`define CTRL_ABT_HI     9

`define DESC_FBE_LO     0
`define DESC_FBE_HI     3
`define DESC_LBE_LO     4
`define DESC_LBE_HI     7
`define DESC_OFF_LO     8
`define DESC_OFF_HI     10
`define DESC_SEQ_LO     16
`define DESC_SEQ_HI     21
`define DESC_LAST_LO    24
`define DESC_LAST_HI    25
`define DESC_KEEP_LO    28
`define DESC_KEEP_HI    30

`define STAT_BUSY       0
`define STAT_TAG_OVF    1
`define STAT_PROG_SEEN  2
`define STAT_PROG_LO    8
`define STAT_PROG_HI    13
`define STAT_TCNT_LO    16
`define STAT_TCNT_HI    18
`define TAG_VALID_BIT   31

`define TAG_DEPTH       4

`endif

// ===== src/beat_buffer.v
// Packet beat store with dword write port and registered beat-wide read with parity.
`timescale 1ns/10ps
`include "rq_host_defines.vh"
module beat_buffer (
    input  wire                 core_clk_in,
    input  wire                 wr_en_in,
    input  wire [1:0]           wr_beat_in,
    input  wire [2:0]           wr_lane_in,
    input  wire [31:0]          wr_data_in,
    input  wire [1:0]           rd_beat_in,
    output reg  [`DATA_W-1:0]   rd_data_out,
    output reg  [31:0]          rd_parity_out
);
    reg [31:0] mem [0:31];
    reg [`DATA_W-1:0] rd_d;
    reg [31:0]        par_d;
    integer i;

    always @(posedge core_clk_in) begin
        if (wr_en_in) begin
            mem[{wr_beat_in, wr_lane_in}] <= wr_data_in;
        end
    end

    always @* begin
        rd_d  = {`DATA_W{1'b0}};
        par_d = 32'h00000000;
        for (i = 0; i < 8; i = i + 1) begin
            rd_d[i*32 +: 32] = mem[{rd_beat_in, i[2:0]}];
        end
        // Odd parity: the parity bit makes each byte plus its bit hold an odd count of ones.
        for (i = 0; i < 32; i = i + 1) begin
            par_d[i] = ~^rd_d[i*8 +: 8]; // RULE22
        end
    end

    always @(posedge core_clk_in) begin
        rd_data_out   <= rd_d;
        rd_parity_out <= par_d;
    end
endmodule

// ===== src/rq_host.v
// Host controller that frames software-built request packets onto the request stream.
//
// The register offsets and register access over Avalon-MM were left to the implementer.
`timescale 1ns/10ps
`include "rq_host_defines.vh"
module rq_host (
    input  wire                     core_clk_in,
    input  wire                     reset_in,
    input  wire [7:0]               avs_address_in,
    input  wire                     avs_read_in,
    input  wire                     avs_write_in,
    input  wire [31:0]              avs_writedata_in,
    output reg  [31:0]              avs_readdata_out,
    output wire                     avs_waitrequest_out,
    output wire [`DATA_W-1:0]       req_data_bus_out,
    output wire [`SIDEBAND_W-1:0]   req_sideband_bus_out,
    output wire                     req_last_beat_out,
    output wire [`KEEP_W-1:0]       req_dword_keep_out,
    output wire                     req_valid_out,
    input  wire [3:0]               req_ready_in,
    input  wire [5:0]               req_progress_number_in,
    input  wire                     req_progress_number_valid_in,
    input  wire [9:0]               allocated_tag_in,
    input  wire                     allocated_tag_valid_in
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_LOAD = 3'b010;
    localparam [2:0] ST_SEND = 3'b100;

    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg  [1:0]  beat_q;
    reg  [1:0]  beat_d;
    reg         ack_q;

    reg         abort_en_q;
    reg         parity_en_q;
    reg         addr_align_q;
    reg         posted_q;
    reg  [1:0]  abort_beat_q;
    reg  [3:0]  fbe_q;
    reg  [3:0]  lbe_q;
    reg  [2:0]  offset_q;
    reg  [5:0]  seq_q;
    reg  [1:0]  last_idx_q;
    reg  [2:0]  last_keep_q;

    reg         prog_seen_q;
    reg  [5:0]  prog_num_q;
    reg         tag_ovf_q;
    reg  [9:0]  tag_mem_q [0:`TAG_DEPTH-1];
    reg  [2:0]  tag_wr_q;
    reg  [2:0]  tag_rd_q;
    reg         tag_pop_ok_q;

    wire        ready;
    wire        fire;
    wire        busy;
    wire        acc_wr;
    wire        acc_rd;
    wire        buf_sel;
    wire        go;
    wire        abort_now;
    wire        last_now;
    wire [2:0]  tag_count;
    wire        tag_empty;
    wire        tag_full;
    wire        tag_push;
    wire        tag_pop;
    wire [1:0]  rd_beat;
    wire [31:0] beat_parity;
    wire [2:0]  eff_offset;
    wire [`SIDEBAND_W-1:0] sideband;
    reg  [31:0] rd_mux;

    assign ready = req_ready_in[0]; // RULE8
    assign busy  = (state_q != ST_IDLE);

    // The first access cycle always waits; the answer comes at the next edge.
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
    assign acc_wr  = avs_write_in & ack_q;
    assign acc_rd  = avs_read_in & ack_q;
    assign buf_sel = avs_address_in[`BUF_SEL_BIT];
    assign go = acc_wr & ~buf_sel & (avs_address_in == `OFF_CTRL) &
                avs_writedata_in[`CTRL_GO] & ~busy;

    always @(posedge core_clk_in) begin
        if (reset_in) begin
            ack_q        <= 1'b0;
            tag_pop_ok_q <= 1'b0;
        end else begin
            ack_q        <= (avs_read_in | avs_write_in) & ~ack_q;
            // A tag counts as read only if the registered read data showed it as valid.
            tag_pop_ok_q <= avs_read_in & ~ack_q & ~buf_sel &
                            (avs_address_in == `OFF_TAG) & ~tag_empty;
        end
    end

    // Next beat is fetched on the accepting edge, so valid never drops mid-packet.
    assign rd_beat = (state_q == ST_SEND && fire) ? beat_q + 2'd1 : beat_q;

    beat_buffer u_buf (
        .core_clk_in   (core_clk_in),
        .wr_en_in      (acc_wr & buf_sel & ~busy),
        .wr_beat_in    (avs_address_in[6:5]),
        .wr_lane_in    (avs_address_in[4:2]),
        .wr_data_in    (avs_writedata_in),
        .rd_beat_in    (rd_beat),
        .rd_data_out   (req_data_bus_out),
        .rd_parity_out (beat_parity)
    );

    assign req_valid_out = (state_q == ST_SEND); // RULE6
    assign fire = req_valid_out & ready; // RULE7

    // Abort only posted packets, never in the first beat; it stays until accepted.
    assign abort_now = req_valid_out & abort_en_q & posted_q & (abort_beat_q != 2'd0) &
                       (beat_q == abort_beat_q); // RULE19
    // An aborted packet ends in the abort beat, so no later beat needs a sticky flag.
    assign last_now = req_valid_out & ((beat_q == last_idx_q) | abort_now); // RULE3 RULE18
    assign req_last_beat_out = last_now;

    // Only a genuine final beat may be partial; an early abort beat stays full.
    assign req_dword_keep_out = (req_valid_out && beat_q == last_idx_q) ?
                                ~(8'hfe << last_keep_q) :
                                (req_valid_out ? 8'hff : 8'h00); // RULE4 RULE5 RULE1

    assign eff_offset = addr_align_q ? offset_q : 3'd0; // RULE16 RULE15

    assign sideband = {seq_q[5:4],                               // RULE23
                       parity_en_q ? beat_parity : 32'h00000000, // RULE22
                       seq_q[3:0],                               // RULE21
                       12'h000,                                  // RULE24
                       abort_now,                                // RULE17
                       eff_offset,
                       lbe_q,                                    // RULE14
                       fbe_q};                                   // RULE13
    assign req_sideband_bus_out = req_valid_out ? sideband : {`SIDEBAND_W{1'b0}}; // RULE2

    always @* begin
        state_d = state_q;
        beat_d  = beat_q;
        case (state_q)
            ST_IDLE: begin
                beat_d = 2'd0;
                if (go) begin
                    state_d = ST_LOAD;
                end
            end
            ST_LOAD: begin
                state_d = ST_SEND;
            end
            ST_SEND: begin
                if (fire) begin
                    if (last_now) begin
                        state_d = ST_IDLE;
                        beat_d  = 2'd0;
                    end else begin
                        beat_d = beat_q + 2'd1;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
                beat_d  = 2'd0;
            end
        endcase
    end

    always @(posedge core_clk_in) begin
        if (reset_in) begin
            state_q <= ST_IDLE;
            beat_q  <= 2'd0;
        end else begin
            state_q <= state_d;
            beat_q  <= beat_d;
        end
    end

    // Descriptor and control are frozen while a packet is on the bus.
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            abort_en_q   <= 1'b0;
            parity_en_q  <= 1'b0;
            addr_align_q <= 1'b0;
            posted_q     <= 1'b0;
            abort_beat_q <= 2'd0;
            fbe_q        <= 4'h0;
            lbe_q        <= 4'h0;
            offset_q     <= 3'h0;
            seq_q        <= 6'h00;
            last_idx_q   <= 2'd0;
            last_keep_q  <= 3'd7;
        end else if (acc_wr && !buf_sel && !busy) begin
            if (avs_address_in == `OFF_CTRL) begin
                abort_en_q   <= avs_writedata_in[`CTRL_ABORT_EN];
                parity_en_q  <= avs_writedata_in[`CTRL_PARITY_EN];
                addr_align_q <= avs_writedata_in[`CTRL_ADDR_ALIGN];
                posted_q     <= avs_writedata_in[`CTRL_POSTED];
                abort_beat_q <= avs_writedata_in[`CTRL_ABT_HI:`CTRL_ABT_LO];
            end
            if (avs_address_in == `OFF_DESC) begin
                fbe_q       <= avs_writedata_in[`DESC_FBE_HI:`DESC_FBE_LO];
                lbe_q       <= avs_writedata_in[`DESC_LBE_HI:`DESC_LBE_LO];
                offset_q    <= avs_writedata_in[`DESC_OFF_HI:`DESC_OFF_LO];
                seq_q       <= avs_writedata_in[`DESC_SEQ_HI:`DESC_SEQ_LO];
                last_idx_q  <= avs_writedata_in[`DESC_LAST_HI:`DESC_LAST_LO];
                last_keep_q <= avs_writedata_in[`DESC_KEEP_HI:`DESC_KEEP_LO];
            end
        end
    end

    // Progress numbers: a new pulse sets the flag even in a clearing cycle.
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            prog_seen_q <= 1'b0;
            prog_num_q  <= 6'h00;
        end else begin
            if (req_progress_number_valid_in) begin
                prog_seen_q <= 1'b1; // RULE10
                prog_num_q  <= req_progress_number_in; // RULE9
            end else if (acc_wr && !buf_sel && avs_address_in == `OFF_STATUS &&
                         avs_writedata_in[`STAT_PROG_SEEN]) begin
                prog_seen_q <= 1'b0;
            end
        end
    end

    // Tags are kept in arrival order, which matches request order.
    assign tag_count = tag_wr_q - tag_rd_q;
    assign tag_empty = (tag_count == 3'd0);
    assign tag_full  = (tag_count == `TAG_DEPTH);
    assign tag_pop   = acc_rd & tag_pop_ok_q;
    assign tag_push  = allocated_tag_valid_in & (~tag_full | tag_pop); // RULE11 RULE12

    always @(posedge core_clk_in) begin
        if (tag_push) begin
            tag_mem_q[tag_wr_q[1:0]] <= allocated_tag_in;
        end
    end

    always @(posedge core_clk_in) begin
        if (reset_in) begin
            tag_wr_q  <= 3'd0;
            tag_rd_q  <= 3'd0;
            tag_ovf_q <= 1'b0;
        end else begin
            if (tag_push) begin
                tag_wr_q <= tag_wr_q + 3'd1;
            end
            if (tag_pop) begin
                tag_rd_q <= tag_rd_q + 3'd1;
            end
            // A lost tag leaves a request unmatched, so it is flagged until cleared.
            if (allocated_tag_valid_in && !tag_push) begin
                tag_ovf_q <= 1'b1;
            end else if (acc_wr && !buf_sel && avs_address_in == `OFF_STATUS &&
                         avs_writedata_in[`STAT_TAG_OVF]) begin
                tag_ovf_q <= 1'b0;
            end
        end
    end

    always @* begin
        rd_mux = 32'h00000000;
        if (!buf_sel) begin
            case (avs_address_in)
                `OFF_CTRL: begin
                    rd_mux[`CTRL_GO]                   = busy;
                    rd_mux[`CTRL_ABORT_EN]             = abort_en_q;
                    rd_mux[`CTRL_PARITY_EN]            = parity_en_q;
                    rd_mux[`CTRL_ADDR_ALIGN]           = addr_align_q;
                    rd_mux[`CTRL_POSTED]               = posted_q;
                    rd_mux[`CTRL_ABT_HI:`CTRL_ABT_LO]  = abort_beat_q;
                end
                `OFF_DESC: begin
                    rd_mux[`DESC_FBE_HI:`DESC_FBE_LO]   = fbe_q;
                    rd_mux[`DESC_LBE_HI:`DESC_LBE_LO]   = lbe_q;
                    rd_mux[`DESC_OFF_HI:`DESC_OFF_LO]   = offset_q;
                    rd_mux[`DESC_SEQ_HI:`DESC_SEQ_LO]   = seq_q;
                    rd_mux[`DESC_LAST_HI:`DESC_LAST_LO] = last_idx_q;
                    rd_mux[`DESC_KEEP_HI:`DESC_KEEP_LO] = last_keep_q;
                end
                `OFF_STATUS: begin
                    rd_mux[`STAT_BUSY]                   = busy;
                    rd_mux[`STAT_TAG_OVF]                = tag_ovf_q;
                    rd_mux[`STAT_PROG_SEEN]              = prog_seen_q;
                    rd_mux[`STAT_PROG_HI:`STAT_PROG_LO]  = prog_num_q;
                    rd_mux[`STAT_TCNT_HI:`STAT_TCNT_LO]  = tag_count;
                end
                `OFF_TAG: begin
                    rd_mux[`TAG_VALID_BIT] = ~tag_empty;
                    rd_mux[9:0]            = tag_empty ? 10'h000 : tag_mem_q[tag_rd_q[1:0]];
                end
                default: begin
                    rd_mux = 32'h00000000;
                end
            endcase
        end
    end

    // Read data is registered in the waiting cycle and stands at the answering edge.
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            avs_readdata_out <= 32'h00000000;
        end else if (avs_read_in && !ack_q) begin
            avs_readdata_out <= rd_mux;
        end
    end
endmodule

// ===== verification/rq_host_checker.sv
// Checker for the request stream outputs of the host controller.
`timescale 1ns/10ps
`include "rq_host_defines.vh"
module rq_host_checker (
    input logic                   core_clk_in,
    input logic                   reset_in,
    input logic [`DATA_W-1:0]     req_data_bus_out,
    input logic [`SIDEBAND_W-1:0] req_sideband_bus_out,
    input logic                   req_last_beat_out,
    input logic [`KEEP_W-1:0]     req_dword_keep_out,
    input logic                   req_valid_out,
    input logic [3:0]             req_ready_in
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    wire        v  = req_valid_out;
    wire        l  = req_last_beat_out;
    wire        a  = req_valid_out && req_ready_in[0];
    wire [61:0] sb = req_sideband_bus_out;
    wire [7:0]  kp = req_dword_keep_out;
    wire [31:0] par;
    genvar i;
    for (i = 0; i < 32; i = i + 1) begin : g_par
        assign par[i] = ~^req_data_bus_out[8*i+:8];
    end
    property p_idle;
        !v |-> sb == 62'h0 && kp == 8'h00 && !l;
    endproperty
    property p_hold;
        v && !req_ready_in[0] |=> v && $stable(req_data_bus_out) && $stable(sb)
            && $stable(kp) && $stable(l);
    endproperty
    property p_cont;
        v && !(a && l) |=> v;
    endproperty
    property p_end;
        a && l |=> !v;
    endproperty
    property p_keep_full;
        v && !l |-> kp == 8'hff;
    endproperty
    property p_keep_low;
        v |-> kp[0] && (kp & (kp + 8'h01)) == 8'h00;
    endproperty
    property p_unused;
        v |-> sb[23:12] == 12'h000;
    endproperty
    property p_parity;
        v |-> sb[59:28] == 32'h0 || sb[59:28] == par;
    endproperty
    property p_abort_first;
        $rose(v) |-> !sb[11];
    endproperty
    property p_abort_ends;
        v && sb[11] |-> l;
    endproperty
    a_idle: assert property (p_idle) else $error("stream fields set while idle");
    a_hold: assert property (p_hold) else $error("beat changed while stalled");
    a_cont: assert property (p_cont) else $error("valid dropped inside packet");
    a_end: assert property (p_end) else $error("valid held after last beat");
    a_keep_full: assert property (p_keep_full) else $error("keep partial early");
    a_keep_low: assert property (p_keep_low) else $error("keep not contiguous");
    a_unused: assert property (p_unused) else $error("unused sideband bits set");
    a_parity: assert property (p_parity) else $error("parity not odd per byte");
    a_abort_first: assert property (p_abort_first) else $error("abort in first beat");
    a_abort_ends: assert property (p_abort_ends) else $error("abort beat not last");
    c_stall: cover property (v && !req_ready_in[0] ##1 a);
    c_multi: cover property (a && !l ##1 a && l);
    c_abort: cover property (a && sb[11]);
endmodule
bind rq_host rq_host_checker rq_host_checker_inst (.core_clk_in, .reset_in,
    .req_data_bus_out, .req_sideband_bus_out, .req_last_beat_out, .req_dword_keep_out,
    .req_valid_out, .req_ready_in);

// ===== verification/rq_dev_model.sv
// Behavioural model of the device end of the request stream.
`timescale 1ns/10ps
module rq_dev_model (
    input  logic        core_clk_in,
    input  logic        reset_in,
    input  logic        slow_in,
    input  logic        valid_in,
    input  logic        last_in,
    input  logic [61:0] sideband_in,
    output logic [3:0]  ready_out,
    output logic [5:0]  progress_out,
    output logic        progress_valid_out,
    output logic [9:0]  tag_out,
    output logic        tag_valid_out
);
    integer     seed = 32'h93426cf3;
    integer     nullified;
    logic       first_q, abort_q;
    logic [5:0] seq_q, ev_q;
    wire        acc = valid_in && ready_out[0];
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            ready_out <= 4'h0;
            first_q <= 1'b1;
            abort_q <= 1'b0;
            ev_q <= 6'h00;
            progress_out <= 6'h15;
            progress_valid_out <= 1'b0;
            tag_valid_out <= 1'b0;
            tag_out <= 10'h2f0;
            nullified = 0;
        end else begin
            // A slow device drops ready at random, also in mid-packet.
            ready_out <= {4{!slow_in || $random(seed) % 3 != 0}};
            ev_q <= {ev_q[4:0], acc && last_in};
            if (acc && first_q) seq_q <= {sideband_in[61:60], sideband_in[27:24]};
            if (acc) first_q <= last_in;
            if (acc) abort_q <= (abort_q || sideband_in[11]) && !last_in;
            if (acc && last_in && (abort_q || sideband_in[11])) nullified = nullified + 1;
            progress_valid_out <= ev_q[1];
            // Outside a pulse the number shows junk, so a late capture is caught.
            progress_out <= ev_q[1] ? seq_q : ~progress_out;
            tag_valid_out <= ev_q[4];
            if (ev_q[4]) tag_out <= tag_out + 10'h05b;
        end
    end
endmodule

// ===== verification/tb_rq_host.sv
// Self-checking bench for the request stream host controller.
`timescale 1ns/10ps
`include "rq_host_defines.vh"
module tb_rq_host;
    logic               clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, slow = 1'b1;
    logic [7:0]         addr = 8'h00;
    logic [31:0]        wdata = 32'h0, rdata, rdq;
    logic               wq, last, valid, pv, tv;
    logic [255:0]       data;
    logic [61:0]        sb;
    logic [7:0]         keep;
    logic [3:0]         ready;
    logic [5:0]         prog;
    logic [9:0]         tag, exp_tag = 10'h34b;
    integer             seed = 32'h93426cf3, num_errors = 0, cmp_count = 0, nb = 0;
    integer             exp_null = 0, p;
    logic [31:0]        dw [0:31];
    logic [255:0]       g_data [0:3];
    logic [61:0]        g_sb [0:3];
    logic [7:0]         g_keep [0:3];
    logic               g_last [0:3];
    initial forever #2 clk = ~clk;
    rq_host rq_host_inst (.core_clk_in(clk), .reset_in(rst), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdq),
        .avs_waitrequest_out(wq), .req_data_bus_out(data), .req_sideband_bus_out(sb),
        .req_last_beat_out(last), .req_dword_keep_out(keep), .req_valid_out(valid),
        .req_ready_in(ready), .req_progress_number_in(prog), .req_progress_number_valid_in(pv),
        .allocated_tag_in(tag), .allocated_tag_valid_in(tv));
    rq_dev_model rq_dev_model_inst (.core_clk_in(clk), .reset_in(rst), .slow_in(slow),
        .valid_in(valid), .last_in(last), .sideband_in(sb), .ready_out(ready),
        .progress_out(prog), .progress_valid_out(pv), .tag_out(tag), .tag_valid_out(tv));
    always @(posedge clk) begin
        if (valid && ready[0] && nb < 4) begin
            g_data[nb] = data;
            g_sb[nb] = sb;
            g_keep[nb] = keep;
            g_last[nb] = last;
            nb = nb + 1;
        end
    end
    task automatic check(input string what, input logic [255:0] exp, input logic [255:0] got);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask
    // Waitrequest and read data are sampled at the rising edge, before that edge updates them.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        integer k;
        k = 0;
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        while (wq !== 1'b0 && k < 40) begin
            @(posedge clk);
            k = k + 1;
        end
        if (k >= 40) num_errors = num_errors + 1;
        rdata = rdq;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    function automatic logic [31:0] par(input logic [255:0] d);
        for (int j = 0; j < 32; j++) par[j] = ~^d[8*j+:8];
    endfunction
    task automatic pkt(input logic [31:0] r);
        logic [255:0] e;
        logic [3:0]   c;
        logic         abt;
        integer       eb, k, j;
        c = r[25:22];
        for (k = 0; k < 8 * (r[1:0] + 1); k++) begin
            dw[k] = $random(seed);
            bus(1'b1, 8'h80 + 8'(k * 4), dw[k]);
        end
        bus(1'b1, `OFF_DESC, {1'b0, r[4:2], 2'b00, r[1:0], 2'b00, r[21:16], 5'h00, r[15:5]});
        nb = 0;
        bus(1'b1, `OFF_CTRL, {22'h0, r[27:26], 3'h0, c, 1'b1});
        abt = c[0] && c[3] && r[27:26] != 2'd0 && r[27:26] <= r[1:0];
        eb = abt ? r[27:26] : r[1:0];
        exp_null = exp_null + abt;
        k = 0;
        do begin
            bus(1'b0, `OFF_STATUS, 32'h0);
            k = k + 1;
        end while (rdata[0] !== 1'b0 && k < 60);
        if (rdata[0] !== 1'b0) num_errors = num_errors + 1;
        repeat (8) @(posedge clk);
        check("beats", eb + 1, nb);
        for (k = 0; k <= eb; k++) begin
            for (j = 0; j < 8; j++) e[32*j+:32] = dw[8*k+j];
            check("data", e, g_data[k]);
            check("keep", k == r[1:0] ? 8'((16'h1 << (r[4:2] + 1)) - 1) : 8'hff, g_keep[k]);
            check("last", k == eb, g_last[k]);
            check("abort", abt && k == eb, g_sb[k][11]);
            check("parity", c[1] ? par(e) : 32'h0, g_sb[k][59:28]);
        end
        check("byte enables", r[12:5], g_sb[0][7:0]);
        check("offset", c[2] ? r[15:13] : 3'h0, g_sb[0][10:8]);
        check("seq", r[21:16], {g_sb[0][61:60], g_sb[0][27:24]});
        bus(1'b0, `OFF_STATUS, 32'h0);
        check("progress", {1'b1, r[21:16]}, {rdata[2], rdata[13:8]});
        bus(1'b1, `OFF_STATUS, 32'h4);
        $display("packet done: %0d beats", eb + 1);
    endtask
    task automatic tagpop(input logic v);
        bus(1'b0, `OFF_TAG, 32'h0);
        check("tag valid", v, rdata[31]);
        if (v) check("tag", exp_tag, rdata[9:0]);
        if (v) exp_tag = exp_tag + 10'h05b;
    endtask
    task conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, `OFF_CTRL, 32'h0);
        check("ctrl reset", 32'h0, rdata);
        bus(1'b0, `OFF_DESC, 32'h0);
        check("desc reset", 32'h70000000, rdata);
        bus(1'b0, 8'h10, 32'h0);
        check("unmapped", 32'h0, rdata);
        pkt(32'h003fa1e0);
        pkt(32'h03aa703b);
        pkt(32'h06411fff);
        pkt(32'h0450186a);
        pkt(32'h076542f1);
        bus(1'b0, `OFF_STATUS, 32'h0);
        check("tag overflow", {1'b1, 3'd4}, {rdata[1], rdata[18:16]});
        bus(1'b1, `OFF_STATUS, 32'h2);
        for (p = 0; p < 4; p++) tagpop(1'b1);
        tagpop(1'b0);
        exp_tag = exp_tag + 10'h05b;
        for (p = 0; p < 8; p++) begin
            slow <= $random(seed);
            pkt($random(seed));
            tagpop(1'b1);
        end
        check("nullified", exp_null, rq_dev_model_inst.nullified);
        conclude();
    end
    initial begin
        #100000;
        num_errors = num_errors + 1;
        conclude();
    end
endmodule
